// ---- rid_core.sv ----
// Instruction decode and execute control for a 14-bit word, 8-bit datapath
// core. Program memory and the general file space sit outside; the program
// counter bytes, status, hold latch and interrupt enable live here.
// Assumes program memory and file memory answer combinationally on clock.
`timescale 1ns/1ns
`include "rid_params.svh"

module rid_core
  import rid_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // Program memory
  output logic [`RID_PC_WIDTH-1:0]     prog_addr,
  input  wire logic [13:0]             prog_word,
  // File register space
  output logic [6:0]                   file_addr,
  input  wire logic [7:0]              file_rdata,
  output logic [7:0]                   file_wdata,
  output logic                         file_we,
  // Pins and peripheral strobes
  input  wire logic [7:0]              port_pins,
  input  wire logic                    wake,
  output logic                         presc_clear,
  output logic                         wdt_clear,
  output logic                         standby,
  // Avalon-MM slave
  input  wire logic [3:0]              address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  output logic [31:0]                  readdata,
  output logic                         waitrequest
);

  rid_phase_type                  phase;
  logic [13:0]                    ir;
  logic [7:0]                     wreg;
  logic [7:0]                     status;
  logic [7:0]                     pc_low_byte;
  logic [4:0]                     pc_high_byte;
  logic [4:0]                     pc_high_hold_latch;
  logic                           gie;
  logic                           nop_pending;
  logic [`RID_PC_WIDTH-1:0]       stack [8];
  logic [2:0]                     sp;
  logic [7:0]                     pins_meta, pins_sync;
  logic                           wake_meta, wake_sync;
  logic [1:0]                     ctrl;
  logic                           ack;

  logic [`RID_PC_WIDTH-1:0]       pc, next_pc;
  logic [7:0]                     src, res, next_status, bit_mask;
  logic [9:0]                     sum;
  logic                           dest_f, w_we, f_we, z_up, c_up, dc_up;
  logic                           c_new, dc_new, skip, jump, call, pop;
  logic                           interrupt_return_op, watchdog_clear_op, sleep_op, flush, exec;
  logic                           pcl_write, internal;

  // Returns {carry, digit carry, sum}; subtraction uses ~b with cin set
  function automatic logic [9:0] add_byte(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic       cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction : add_byte

  assign pc        = {pc_high_byte, pc_low_byte};
  assign prog_addr = pc;
  assign file_addr = ir[6:0];
  assign exec      = (phase == PH_EXEC) && ctrl[`RID_CTRL_RUN] && !standby;

  // Four clock periods make one instruction cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase <= PH_FETCH;
    end else begin
      unique case (phase)
        PH_FETCH: phase <= PH_LATCH;
        PH_LATCH: phase <= PH_READ;
        PH_READ:  phase <= PH_EXEC;
        PH_EXEC:  phase <= PH_FETCH;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ir <= 14'h0000;
    end else if (phase == PH_LATCH) begin
      ir <= prog_word;
    end
  end

  // Pin levels and wake request cross in from outside
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pins_meta <= 8'h00;
      pins_sync <= 8'h00;
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      pins_meta <= port_pins;
      pins_sync <= pins_meta;
      wake_meta <= wake;
      wake_sync <= wake_meta;
    end
  end

  // Operand source; core-held registers override the external file space
  always_comb begin
    internal = 1'b1;
    unique case (ir[6:0])
      `RID_F_PCL:    src = pc_low_byte;
      `RID_F_STATUS: src = status;
      `RID_F_PC_HIGH_HOLD_LATCH: src = {3'h0, pc_high_hold_latch};
      `RID_F_INTCON: src = {gie, 7'h00};
      `RID_F_PORT: begin
        src      = pins_sync;
        internal = 1'b0;
      end
      default: begin
        src      = file_rdata;
        internal = 1'b0;
      end
    endcase
  end

  // Decode and datapath
  always_comb begin
    res      = 8'h00;
    dest_f   = 1'b0;
    w_we     = 1'b0;
    f_we     = 1'b0;
    z_up     = 1'b0;
    c_up     = 1'b0;
    dc_up    = 1'b0;
    c_new    = status[`RID_ST_C];
    dc_new   = status[`RID_ST_DC];
    skip     = 1'b0;
    jump     = 1'b0;
    call     = 1'b0;
    pop      = 1'b0;
    interrupt_return_op   = 1'b0;
    watchdog_clear_op   = 1'b0;
    sleep_op = 1'b0;
    sum      = 10'h000;
    bit_mask = 8'h01 << ir[9:7];
    unique case (ir[13:12])
      2'b00: begin
        dest_f = 1'b1;
        unique case (ir[11:8])
          4'h0: begin
            dest_f = 1'b0;
            if (ir[7]) begin
              res  = wreg;
              f_we = 1'b1;
            end else begin
              unique case (ir[7:0])
                `RID_OP_RETURN: pop = 1'b1;
                `RID_OP_INTERRUPT_RETURN_OP: begin
                  pop    = 1'b1;
                  interrupt_return_op = 1'b1;
                end
                `RID_OP_WATCHDOG_CLEAR_OP: watchdog_clear_op = 1'b1;
                `RID_OP_SLEEP:  sleep_op = 1'b1;
                default: ;
              endcase
            end
          end
          4'h1: begin
            res  = 8'h00;
            z_up = 1'b1;
          end
          4'h2, 4'h7: begin
            if (ir[10:8] == 3'h2) begin
              sum = add_byte(src, ~wreg, 1'b1);
            end else begin
              sum = add_byte(src, wreg, 1'b0);
            end
            res    = sum[7:0];
            c_new  = sum[9];
            dc_new = sum[8];
            z_up   = 1'b1;
            c_up   = 1'b1;
            dc_up  = 1'b1;
          end
          4'h3: begin
            res  = src - 8'h01;
            z_up = 1'b1;
          end
          4'h4: begin
            res  = src | wreg;
            z_up = 1'b1;
          end
          4'h5: begin
            res  = src & wreg;
            z_up = 1'b1;
          end
          4'h6: begin
            res  = src ^ wreg;
            z_up = 1'b1;
          end
          4'h8: begin
            res  = src;
            z_up = 1'b1;
          end
          4'h9: begin
            res  = ~src;
            z_up = 1'b1;
          end
          4'hA: begin
            res  = src + 8'h01;
            z_up = 1'b1;
          end
          4'hB: begin
            res  = src - 8'h01;
            skip = (res == 8'h00);
          end
          4'hC: begin
            res   = {status[`RID_ST_C], src[7:1]};
            c_new = src[0];
            c_up  = 1'b1;
          end
          4'hD: begin
            res   = {src[6:0], status[`RID_ST_C]};
            c_new = src[7];
            c_up  = 1'b1;
          end
          4'hE: res = {src[3:0], src[7:4]};
          4'hF: begin
            res  = src + 8'h01;
            skip = (res == 8'h00);
          end
        endcase
        // CLEAR_ACC_OP shares opcode 0001 with the accumulator as target
        if (dest_f) begin
          w_we = !ir[7];
          f_we = ir[7];
        end
      end
      2'b01: begin
        unique case (ir[11:10])
          2'b00: begin
            res  = src & ~bit_mask;
            f_we = 1'b1;
          end
          2'b01: begin
            res  = src | bit_mask;
            f_we = 1'b1;
          end
          2'b10: skip = ((src & bit_mask) == 8'h00);
          2'b11: skip = ((src & bit_mask) != 8'h00);
        endcase
      end
      2'b10: begin
        call = !ir[11];
        jump = ir[11];
      end
      2'b11: begin
        w_we = 1'b1;
        casez (ir[11:8])
          4'b00??: res = ir[7:0];
          4'b01??: begin
            res = ir[7:0];
            pop = 1'b1;
          end
          4'b1000: begin
            res  = ir[7:0] | wreg;
            z_up = 1'b1;
          end
          4'b1001: begin
            res  = ir[7:0] & wreg;
            z_up = 1'b1;
          end
          4'b1010: begin
            res  = ir[7:0] ^ wreg;
            z_up = 1'b1;
          end
          4'b1011: w_we = 1'b0;
          default: begin
            if (!ir[9]) begin
              sum = add_byte(ir[7:0], ~wreg, 1'b1);
            end else begin
              sum = add_byte(ir[7:0], wreg, 1'b0);
            end
            res    = sum[7:0];
            c_new  = sum[9];
            dc_new = sum[8];
            z_up   = 1'b1;
            c_up   = 1'b1;
            dc_up  = 1'b1;
          end
        endcase
      end
    endcase
  end

  // Next program counter and two-cycle detection
  always_comb begin
    pcl_write = f_we && (ir[6:0] == `RID_F_PCL);
    next_pc   = pc + 13'h0001;
    if (skip) begin
      next_pc = pc + 13'h0002;
    end
    if (jump || call) begin
      next_pc = {pc_high_hold_latch[4:3], ir[10:0]};
    end
    if (pop) begin
      next_pc = stack[sp - 3'h1];
    end
    if (pcl_write) begin
      next_pc = {pc_high_hold_latch, res};
    end
    flush = skip || jump || call || pop || pcl_write;
  end

  // Status: a file write lands first, flag effects then overwrite it
  always_comb begin
    next_status = status;
    if (f_we && ir[6:0] == `RID_F_STATUS) begin
      next_status = {res[7:5], status[4:3], res[2:0]};
    end
    if (z_up) begin
      next_status[`RID_ST_Z] = (res == 8'h00);
    end
    if (c_up) begin
      next_status[`RID_ST_C] = c_new;
    end
    if (dc_up) begin
      next_status[`RID_ST_DC] = dc_new;
    end
    if (watchdog_clear_op || sleep_op) begin
      next_status[`RID_ST_TO] = 1'b1;
      next_status[`RID_ST_PD] = watchdog_clear_op;
    end
  end

  // Program counter, stack and the idle second cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pc_low_byte  <= 8'h00;
      pc_high_byte <= 5'h00;
      sp           <= 3'h0;
      nop_pending  <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        stack[i] <= `RID_RESET_VECTOR;
      end
    end else if (exec) begin
      if (nop_pending) begin
        nop_pending <= 1'b0;
      end else begin
        {pc_high_byte, pc_low_byte} <= next_pc;
        nop_pending <= flush;
        // Stack wraps silently on overflow, as an eight-deep ring
        if (call) begin
          stack[sp] <= pc + 13'h0001;
          sp        <= sp + 3'h1;
        end else if (pop) begin
          sp <= sp - 3'h1;
        end
      end
    end
  end

  // Accumulator, status, hold latch and interrupt enable
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wreg               <= 8'h00;
      status             <= `RID_ST_RESET;
      pc_high_hold_latch <= 5'h00;
      gie                <= 1'b0;
    end else if (exec && !nop_pending) begin
      status <= next_status;
      if (w_we) begin
        wreg <= res;
      end
      if (f_we && ir[6:0] == `RID_F_PC_HIGH_HOLD_LATCH) begin
        pc_high_hold_latch <= res[4:0];
      end
      if (interrupt_return_op) begin
        gie <= 1'b1;
      end else if (f_we && ir[6:0] == `RID_F_INTCON) begin
        gie <= res[`RID_INTCON_GIE];
      end
    end
  end

  // External file writes and peripheral strobes, one clock pulses
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      file_we     <= 1'b0;
      file_wdata  <= 8'h00;
      presc_clear <= 1'b0;
      wdt_clear   <= 1'b0;
    end else begin
      file_we     <= exec && !nop_pending && f_we && !internal;
      file_wdata  <= res;
      presc_clear <= exec && !nop_pending && f_we &&
                     ir[6:0] == `RID_F_TIMER &&
                     ctrl[`RID_CTRL_PRESC];
      wdt_clear   <= exec && !nop_pending && (watchdog_clear_op || sleep_op);
    end
  end

  // Standby holds execution until a synchronised wake arrives
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      standby <= 1'b0;
    end else if (wake_sync) begin
      standby <= 1'b0;
    end else if (exec && !nop_pending && sleep_op) begin
      standby <= 1'b1;
    end
  end

  // Avalon slave: one wait state, read data prepared in the waiting cycle
  assign waitrequest = (read || write) && !ack;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack      <= 1'b0;
      ctrl     <= `RID_CTRL_RESET;
      readdata <= 32'h00000000;
    end else begin
      ack <= (read || write) && !ack;
      if (write && ack && address == `RID_REG_CTRL) begin
        ctrl <= writedata[1:0];
      end
      if (read && !ack) begin
        unique case (address)
          `RID_REG_CTRL: readdata <= {30'h0, ctrl};
          `RID_REG_CORE: readdata <= {14'h0, standby, gie, status, wreg};
          `RID_REG_PC:   readdata <= {16'h0, sp, pc};
          default:       readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : rid_core

// ---- rid_core_sva.sv ----
// Checker for rid_core: bus wait state, write strobes, pc stand time.
// Assumes it is bound onto rid_core, which has one clock domain.
`timescale 1ns/1ns
`include "rid_params.svh"

module rid_core_sva (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rstn,
  // Program and file side
  input  wire logic [`RID_PC_WIDTH-1:0] prog_addr,
  input  wire logic [6:0]               file_addr,
  input  wire logic                     file_we,
  // Pins and strobes
  input  wire logic                     wake,
  input  wire logic                     presc_clear,
  input  wire logic                     wdt_clear,
  input  wire logic                     standby,
  // Register bus
  input  wire logic [3:0]               address,
  input  wire logic                     read,
  input  wire logic                     write,
  input  wire logic [31:0]              readdata,
  input  wire logic                     waitrequest
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic req = read | write;

  one_wait_a: assert property (req && waitrequest |=> !waitrequest)
    else $error("bus answer not after one wait state");
  unmapped_zero_a: assert property (read && !waitrequest && address == 4'hC
    |-> readdata == 32'h0) else $error("unmapped read not zero");
  we_pulse_a: assert property (file_we |=> !file_we)
    else $error("file write longer than one clock");
  core_held_a: assert property (file_we |-> !(file_addr inside
    {7'h02, 7'h03, 7'h0A, 7'h0B})) else $error("core byte written out");
  addr_hold_a: assert property (file_we |-> $stable(file_addr))
    else $error("file address moved under write");
  presc_cause_a: assert property (presc_clear |-> file_we &&
    file_addr == `RID_F_TIMER) else $error("prescaler clear without cause");
  wdt_pulse_a: assert property (wdt_clear |=> !wdt_clear)
    else $error("watchdog clear longer than one clock");
  pc_stand_a: assert property (!$stable(prog_addr)
    |=> $stable(prog_addr) [*3]) else $error("pc held under four clocks");
  wake_exit_a: assert property (wake && standby |-> ##[1:4] !standby)
    else $error("wake did not end standby");

  cover property (presc_clear);
  cover property ($rose(standby));
  cover property (read && !waitrequest);
endmodule : rid_core_sva

bind rid_core rid_core_sva chk (.clock(clock), .rstn(rstn),
  .prog_addr(prog_addr), .file_addr(file_addr), .file_we(file_we),
  .wake(wake), .presc_clear(presc_clear), .wdt_clear(wdt_clear),
  .standby(standby), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest));

// ---- rid_core_tb.sv ----
// Self-checking bench for rid_core: instruction rows, then branch, port,
// prescaler and standby cases. Assumes rid_mem_model, one 100 MHz clock.
`timescale 1ns/1ns
`include "rid_params.svh"

module rid_core_tb;
  typedef struct packed {
    logic [13:0] op;
    logic [7:0]  w, v, ew, ef;
    logic [2:0]  fl;
    logic        sk;
  } rid_row_type;

  logic                     clock = 1'h0;
  logic                     rstn = 1'h0;
  logic [`RID_PC_WIDTH-1:0] prog_addr;
  logic [13:0]              prog_word;
  logic [6:0]               file_addr;
  logic [7:0]               file_rdata, file_wdata;
  logic                     file_we, presc_clear, wdt_clear, standby;
  logic [7:0]               port_pins = 8'h00;
  logic                     wake = 1'h0, read = 1'h0, write = 1'h0;
  logic [3:0]               address = 4'h0;
  logic [31:0]              writedata = 32'h0, readdata, q;
  logic                     waitrequest;
  int                       err_total = 0, check_count = 0, cyc = 0;
  int                       n_presc, n_wdt;
  // op, w, file value, expected w, expected file, {Z,DC,C}, skip
  rid_row_type rows [27] = '{
    '{14'h07A0,8'h0F,8'h01,8'h0F,8'h10,3'h2,1'h0},
    '{14'h0220,8'h05,8'h05,8'h00,8'h05,3'h7,1'h0},
    '{14'h0520,8'h5F,8'hA3,8'h03,8'hA3,3'h0,1'h0},
    '{14'h04A0,8'h00,8'h00,8'h00,8'h00,3'h4,1'h0},
    '{14'h0620,8'h0F,8'hFF,8'hF0,8'hFF,3'h0,1'h0},
    '{14'h09A0,8'h11,8'hFF,8'h11,8'h00,3'h4,1'h0},
    '{14'h0320,8'h11,8'h01,8'h00,8'h01,3'h4,1'h0},
    '{14'h0AA0,8'h11,8'hFF,8'h11,8'h00,3'h4,1'h0},
    '{14'h0820,8'h11,8'h00,8'h00,8'h00,3'h4,1'h0},
    '{14'h0EA0,8'h11,8'h3C,8'h11,8'hC3,3'h0,1'h0},
    '{14'h0DA0,8'h11,8'h81,8'h11,8'h02,3'h1,1'h0},
    '{14'h0C20,8'h11,8'h01,8'h00,8'h01,3'h1,1'h0},
    '{14'h01A0,8'h11,8'h55,8'h11,8'h00,3'h4,1'h0},
    '{14'h0103,8'h77,8'h55,8'h00,8'h55,3'h4,1'h0},
    '{14'h00A0,8'h5A,8'h00,8'h5A,8'h5A,3'h0,1'h0},
    '{14'h11A0,8'h11,8'hFF,8'h11,8'hF7,3'h0,1'h0},
    '{14'h17A0,8'h11,8'h00,8'h11,8'h80,3'h0,1'h0},
    '{14'h3800,8'h00,8'h12,8'h00,8'h12,3'h4,1'h0},
    '{14'h395F,8'hA3,8'h12,8'h03,8'h12,3'h0,1'h0},
    '{14'h3AFF,8'hFF,8'h12,8'h00,8'h12,3'h4,1'h0},
    '{14'h3C10,8'h01,8'h12,8'h0F,8'h12,3'h1,1'h0},
    '{14'h3E10,8'hF0,8'h12,8'h00,8'h12,3'h5,1'h0},
    '{14'h0000,8'h33,8'h44,8'h33,8'h44,3'h0,1'h0},
    '{14'h0BA0,8'h11,8'h01,8'h11,8'h00,3'h0,1'h1},
    '{14'h0F20,8'h11,8'h01,8'h02,8'h01,3'h0,1'h0},
    '{14'h1820,8'h11,8'hFE,8'h11,8'hFE,3'h0,1'h1},
    '{14'h1C20,8'h11,8'hFE,8'h11,8'hFE,3'h0,1'h0}
  };

  rid_core dut (.clock(clock), .rstn(rstn), .prog_addr(prog_addr),
    .prog_word(prog_word), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wdata(file_wdata), .file_we(file_we), .port_pins(port_pins),
    .wake(wake), .presc_clear(presc_clear), .wdt_clear(wdt_clear),
    .standby(standby), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  rid_mem_model mem (.clock(clock), .prog_addr(prog_addr),
    .prog_word(prog_word), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wdata(file_wdata), .file_we(file_we));

  always #5 clock = ~clock;

  always @(posedge clock) begin
    cyc <= cyc + 1;
    // Strobe counts restart with every reset of the design
    n_presc <= rstn ? n_presc + int'(presc_clear === 1'h1) : 0;
    n_wdt <= rstn ? n_wdt + int'(wdt_clear === 1'h1) : 0;
    if (cyc == 10000) begin
      err_total++;
      test_done();
    end
  end

  task automatic test_done;
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic cmp(input logic [15:0] g, e, input string m);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s: %h vs %h", $time, m, g, e);
    end
  endtask : cmp

  // Request holds until the rising edge that sees waitrequest low; data is
  // taken and the request released at that same edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clock);
    while (waitrequest !== 1'h0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n == 20) begin
      err_total++;
      $display("[FAIL] %0t bus hang", $time);
    end
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask : bus

  task automatic clr;
    for (int i = 0; i < 2048; i++) mem.pmem[i] = 14'h0000;
    mem.fmem[7'h21] = 8'hEE;
  endtask : clr

  // Reset, run with the given control word, then read the core state
  task automatic start(input logic [7:0] c);
    rstn <= 1'h0;
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    bus(1'h1, `RID_REG_CTRL, {24'h0, c});
    repeat (120) @(posedge clock);
    bus(1'h0, `RID_REG_CORE, 32'h0);
  endtask : start

  initial begin
    clr();
    start(8'h00);
    cmp(q[15:0], 16'h1800, "core reset");
    bus(1'h1, `RID_REG_CORE, 32'hFFFF);
    bus(1'h0, `RID_REG_CORE, 32'h0);
    cmp(q[15:0], 16'h1800, "core read only");
    bus(1'h0, `RID_REG_PC, 32'h0);
    cmp(q[15:0], 16'h0000, "pc reset");
    bus(1'h1, 4'hC, 32'h5);
    bus(1'h0, 4'hC, 32'h0);
    cmp(q[15:0] | q[31:16], 16'h0000, "unmapped");
    bus(1'h1, `RID_REG_CTRL, 32'h3);
    bus(1'h0, `RID_REG_CTRL, 32'h0);
    cmp(q[15:0], 16'h0003, "ctrl");
    foreach (rows[i]) begin
      clr();
      mem.pmem[0] = {6'h30, rows[i].w};
      mem.pmem[1] = rows[i].op;
      mem.pmem[2] = 14'h00A1;
      mem.pmem[3] = 14'h2803;
      mem.fmem[7'h20] = rows[i].v;
      start(8'h01);
      cmp(q[15:0], {5'h03, rows[i].fl, rows[i].ew}, "row core");
      cmp(16'(mem.fmem[7'h20]), 16'(rows[i].ef), "row file");
      cmp(16'(mem.fmem[7'h21]), rows[i].sk ? 16'h00EE :
          16'(rows[i].ew), "row skip");
    end
    clr();
    mem.pmem[0] = 14'h3005;
    mem.pmem[1] = 14'h008A;
    mem.pmem[2] = 14'h3040;
    mem.pmem[3] = 14'h0082;
    mem.pmem[13'h540] = 14'h00A1;
    mem.pmem[13'h541] = 14'h0802;
    mem.pmem[13'h542] = 14'h00A2;
    mem.pmem[13'h543] = 14'h2D43;
    start(8'h01);
    cmp(16'(mem.fmem[7'h21]), 16'h0040, "pc low write");
    cmp(16'(mem.fmem[7'h22]), 16'h0041, "pc low read");
    bus(1'h0, `RID_REG_PC, 32'h0);
    cmp(q[15:0], 16'h0543, "pc high from latch");
    clr();
    mem.pmem[0] = 14'h2010;
    mem.pmem[1] = 14'h2018;
    mem.pmem[2] = 14'h00A1;
    mem.pmem[3] = 14'h2803;
    mem.pmem[16] = 14'h2020;
    mem.pmem[17] = 14'h3499;
    mem.pmem[24] = 14'h0009;
    mem.pmem[32] = 14'h0008;
    start(8'h01);
    cmp(16'(mem.fmem[7'h21]), 16'h0099, "literal return");
    cmp(q[31:16] & 16'h0001, 16'h0001, "global enable");
    bus(1'h0, `RID_REG_PC, 32'h0);
    cmp(q[15:0], 16'h0003, "call and return");
    clr();
    mem.fmem[7'h06] = 8'hFF;
    port_pins <= 8'h0F;
    mem.pmem[0] = 14'h0886;
    mem.pmem[1] = 14'h2801;
    start(8'h01);
    cmp(16'(mem.fmem[7'h06]), 16'h000F, "port from pins");
    for (int k = 0; k < 2; k++) begin
      clr();
      mem.pmem[0] = 14'h0181;
      mem.pmem[1] = 14'h0801;
      mem.pmem[2] = 14'h2802;
      start(k == 0 ? 8'h03 : 8'h01);
      cmp(16'(n_presc), k == 0 ? 16'h1 : 16'h0, "prescaler");
    end
    clr();
    mem.pmem[0] = 14'h0064;
    mem.pmem[1] = 14'h0063;
    mem.pmem[2] = 14'h3012;
    mem.pmem[3] = 14'h00A1;
    mem.pmem[4] = 14'h2804;
    start(8'h01);
    cmp(16'(standby), 16'h0001, "standby");
    cmp(16'(q[15:8]), 16'h0010, "standby flags");
    cmp(16'(n_wdt), 16'h0002, "watchdog clear");
    wake <= 1'h1;
    repeat (60) @(posedge clock);
    wake <= 1'h0;
    cmp(16'(standby), 16'h0000, "wake");
    cmp(16'(mem.fmem[7'h21]), 16'h0012, "resume");
    test_done();
  end
endmodule : rid_core_tb

// ---- rid_mem_model.sv ----
// Program and file memory beside rid_core; both answer at once.
// Assumes the bench preloads both arrays by hierarchical reference.
`timescale 1ns/1ns

module rid_mem_model (
  // Clock
  input  wire logic        clock,
  // Program memory
  input  wire logic [12:0] prog_addr,
  output logic      [13:0] prog_word,
  // File space
  input  wire logic [6:0]  file_addr,
  output logic      [7:0]  file_rdata,
  input  wire logic [7:0]  file_wdata,
  input  wire logic        file_we
);
  logic [13:0] pmem [0:8191];
  logic [7:0]  fmem [0:127];

  assign prog_word  = pmem[prog_addr];
  assign file_rdata = fmem[file_addr];

  // Plain always, so the bench may preload bytes between runs
  always @(posedge clock) begin
    if (file_we) begin
      fmem[file_addr] <= file_wdata;
    end
  end
endmodule : rid_mem_model

// ---- rid_params.svh ----
// Constants of the instruction decode and execute block: file addresses,
// status field positions, reset values, opcode fields, bus offsets, timing.
// Holds macros only, so its includers may place it outside any module or package.
//
// Functional notes
// - Reading the low program counter byte yields its current value.
// - Writing the low byte also copies the hold latch into the high byte.
// - Bit set and clear read the whole byte and write it back.
// - Self-modifying port instructions read the pin levels, not latches.
// - File writes to the timer clear the prescaler when it is assigned.
// - Program counter changes and true skips take two cycles, second idle.
// - Add, subtract, and, or, xor file ops with their flag effects.
// - Decrement and increment skip write result, skip on zero, no flags.
// - Rotates pass through carry; only carry changes.
// - Bit clear, set, skip-if-clear, skip-if-set; no flag changes.
// - Call pushes return address, jump loads target, return pops.
// - Interrupt return pops and re-enables global interrupts.
// - Literal return loads the literal into the accumulator and pops.
// - Literal or, and, xor update the accumulator and zero only.
// - Literal subtract is literal minus accumulator; add sums; full flags.
// - Watchdog clear resets the watchdog and sets timeout, powerdown.
// - Standby enters low power and updates timeout and powerdown.
// - Destination bit zero selects accumulator, one selects the file.
// - One instruction cycle lasts four clock periods.
`ifndef RID_PARAMS_SVH
`define RID_PARAMS_SVH

`define RID_PC_WIDTH      13
`define RID_RESET_VECTOR  13'h0000
`define RID_PHASES        4

`define RID_F_TIMER       7'h01
`define RID_F_PCL         7'h02
`define RID_F_STATUS      7'h03
`define RID_F_PORT        7'h06
`define RID_F_PC_HIGH_HOLD_LATCH      7'h0A
`define RID_F_INTCON      7'h0B

`define RID_ST_C          0
`define RID_ST_DC         1
`define RID_ST_Z          2
`define RID_ST_PD         3
`define RID_ST_TO         4
`define RID_ST_RESET      8'h18
`define RID_INTCON_GIE    7

`define RID_OP_RETURN     8'h08
`define RID_OP_INTERRUPT_RETURN_OP     8'h09
`define RID_OP_SLEEP      8'h63
`define RID_OP_WATCHDOG_CLEAR_OP     8'h64

`define RID_REG_CTRL      4'h0
`define RID_REG_CORE      4'h4
`define RID_REG_PC        4'h8
`define RID_CTRL_RUN      0
`define RID_CTRL_PRESC    1
`define RID_CTRL_RESET    2'h0

`endif

// ---- rid_pkg.sv ----
// Types shared by the instruction decode and execute block.
// Assumes nothing of its surroundings.
package rid_pkg;

  // Gray sequence: fetch, latch word, settle file read, execute
  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_LATCH = 2'b01,
    PH_READ  = 2'b11,
    PH_EXEC  = 2'b10
  } rid_phase_type;

endpackage : rid_pkg
